// ### src/spi_regs.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module spi_regs
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event inputs, same clock, one per source
    input  wire logic        baseGuardEvt,
    input  wire logic        sysctrlGuardEvt,
    input  wire logic        ahbExpGuardEvt,
    input  wire logic        coreBridgeErrEvt,
    // Interrupt requests
    output logic             baseGuardIrq,
    output logic             sysctrlGuardIrq,
    output logic             ahbExpGuardIrq,
    output logic             coreBridgeErrIrq,
    // Access setting for the external controller
    output logic             expansionNonSecure
);
    import spi_pkg::*;

    //=========================================================================
    // Decode
    function automatic logic isAddr(input logic [11:0] a, input logic [11:0] ofs);
        isAddr = (a[11:2] == ofs[11:2]);
    endfunction

    logic                     wrStb;
    logic                     rdStb;
    logic [SPI_NUM_SRC-1:0]   evtVec;
    logic [SPI_NUM_SRC-1:0]   clrVec;
    logic [SPI_NUM_SRC-1:0]   pendVec;
    logic [SPI_NUM_SRC-1:0]   enable_r;
    logic                     access_r;
    logic [31:0]              rdData;
    logic                     mapped;

    // Single-cycle access phase: writes take effect on the pready edge
    assign wrStb = psel & penable & pwrite & pready;
    assign rdStb = psel & ~penable & ~pwrite;

    assign evtVec = {coreBridgeErrEvt, ahbExpGuardEvt, sysctrlGuardEvt, baseGuardEvt};

    //=========================================================================
    // Clear pulses, decoded from the write data and never stored
    always_comb
    begin
        clrVec = SPI_RST_VEC;
        if (wrStb && isAddr(paddr, SPI_OFS_PROT_CLEAR))
        begin
            clrVec[SPI_SRC_AHB_EXP] = pwdata[SPI_BIT_AHB_EXP];
            clrVec[SPI_SRC_SYSCTRL] = pwdata[SPI_BIT_SYSCTRL];
            clrVec[SPI_SRC_BASE]    = pwdata[SPI_BIT_BASE];
        end
        if (wrStb && isAddr(paddr, SPI_OFS_BRG_CLEAR))
            clrVec[SPI_SRC_BRIDGE] = pwdata[SPI_BIT_BRIDGE];
    end

    //=========================================================================
    // Pending flags
    genvar gi;
    generate
        for (gi = 0; gi < SPI_NUM_SRC; gi++)
        begin : gFlag
            spi_flag uFlag
            (
                .mclk   (mclk),
                .reset  (reset),
                .clkEn  (clkEn),
                .setEvt (evtVec[gi]),
                .clrEvt (clrVec[gi]),
                .flag   (pendVec[gi])
            );
        end
    endgenerate

    //=========================================================================
    // Enables
    always_ff @(posedge mclk)
    begin
        if (reset)
            enable_r <= SPI_RST_VEC;
        else if (clkEn && wrStb)
        begin
            if (isAddr(paddr, SPI_OFS_PROT_ENABLE))
            begin
                enable_r[SPI_SRC_AHB_EXP] <= pwdata[SPI_BIT_AHB_EXP];
                enable_r[SPI_SRC_SYSCTRL] <= pwdata[SPI_BIT_SYSCTRL];
                enable_r[SPI_SRC_BASE]    <= pwdata[SPI_BIT_BASE];
            end
            if (isAddr(paddr, SPI_OFS_BRG_ENABLE))
                enable_r[SPI_SRC_BRIDGE] <= pwdata[SPI_BIT_BRIDGE];
        end
    end

    //=========================================================================
    // Access setting
    always_ff @(posedge mclk)
    begin
        if (reset)
            access_r <= SPI_RST_BIT;
        else if (clkEn && wrStb && isAddr(paddr, SPI_OFS_EXP_ACCESS))
            access_r <= pwdata[SPI_BIT_ACCESS];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            expansionNonSecure <= SPI_RST_BIT;
        else if (clkEn)
            expansionNonSecure <= access_r;
    end

    //=========================================================================
    // Interrupt outputs, registered so they follow flag and enable by one cycle
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            baseGuardIrq     <= SPI_RST_BIT;
            sysctrlGuardIrq  <= SPI_RST_BIT;
            ahbExpGuardIrq   <= SPI_RST_BIT;
            coreBridgeErrIrq <= SPI_RST_BIT;
        end
        else if (clkEn)
        begin
            baseGuardIrq     <= pendVec[SPI_SRC_BASE] & enable_r[SPI_SRC_BASE];
            sysctrlGuardIrq  <= pendVec[SPI_SRC_SYSCTRL] & enable_r[SPI_SRC_SYSCTRL];
            ahbExpGuardIrq   <= pendVec[SPI_SRC_AHB_EXP] & enable_r[SPI_SRC_AHB_EXP];
            coreBridgeErrIrq <= pendVec[SPI_SRC_BRIDGE] & enable_r[SPI_SRC_BRIDGE];
        end
    end

    //=========================================================================
    // Read mux; reserved bits stay zero
    always_comb
    begin
        rdData = SPI_RST_WORD;
        mapped = 1'b1;
        if (isAddr(paddr, SPI_OFS_PROT_STATUS))
        begin
            rdData[SPI_BIT_AHB_EXP] = pendVec[SPI_SRC_AHB_EXP];
            rdData[SPI_BIT_SYSCTRL] = pendVec[SPI_SRC_SYSCTRL];
            rdData[SPI_BIT_BASE]    = pendVec[SPI_SRC_BASE];
        end
        else if (isAddr(paddr, SPI_OFS_PROT_ENABLE))
        begin
            rdData[SPI_BIT_AHB_EXP] = enable_r[SPI_SRC_AHB_EXP];
            rdData[SPI_BIT_SYSCTRL] = enable_r[SPI_SRC_SYSCTRL];
            rdData[SPI_BIT_BASE]    = enable_r[SPI_SRC_BASE];
        end
        else if (isAddr(paddr, SPI_OFS_BRG_STATUS))
            rdData[SPI_BIT_BRIDGE] = pendVec[SPI_SRC_BRIDGE];
        else if (isAddr(paddr, SPI_OFS_BRG_ENABLE))
            rdData[SPI_BIT_BRIDGE] = enable_r[SPI_SRC_BRIDGE];
        else if (isAddr(paddr, SPI_OFS_EXP_ACCESS))
            rdData[SPI_BIT_ACCESS] = access_r;
        else if (isAddr(paddr, SPI_OFS_PROT_CLEAR) || isAddr(paddr, SPI_OFS_BRG_CLEAR))
            rdData = SPI_RST_WORD;
        else
            mapped = 1'b0;
    end

    //=========================================================================
    // APB answer: pready rises in the access cycle, data captured in setup
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pready  <= SPI_RST_BIT;
            pslverr <= SPI_RST_BIT;
            prdata  <= SPI_RST_WORD;
        end
        else if (clkEn)
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (rdStb)
                prdata <= rdData;
        end
    end
endmodule // spi_regs

// ### inc/spi_pkg.sv
//=============================================================================
// Overview of operation
// - Write one to bit 20 clears expansion pending
// - Write one bit1/bit0 clears APB guard pending
// - Clear registers pulse, never store written ones
// - Enable bit 20 gates expansion interrupt
// - Enable bits 1,0 gate APB guard interrupts
// - Bridge status bit 0 read-only, resets zero
// - Write one bridge clear bit 0 clears pending
// - Bridge enable bit 0 gates bridge interrupt
// - Access setting bit0: 0 secure, 1 non-secure
// - Bridge status ignores software writes
// - Protection status bits 20,1,0 report pending
package spi_pkg;
    //=========================================================================
    // Register byte offsets
    localparam logic [11:0] SPI_OFS_PROT_STATUS  = 12'h020;
    localparam logic [11:0] SPI_OFS_PROT_CLEAR   = 12'h024;
    localparam logic [11:0] SPI_OFS_PROT_ENABLE  = 12'h028;
    localparam logic [11:0] SPI_OFS_BRG_STATUS   = 12'h040;
    localparam logic [11:0] SPI_OFS_BRG_CLEAR    = 12'h044;
    localparam logic [11:0] SPI_OFS_BRG_ENABLE   = 12'h048;
    localparam logic [11:0] SPI_OFS_EXP_ACCESS   = 12'h060;
    //=========================================================================
    // Field positions
    localparam int SPI_BIT_AHB_EXP  = 20;
    localparam int SPI_BIT_SYSCTRL  = 1;
    localparam int SPI_BIT_BASE     = 0;
    localparam int SPI_BIT_BRIDGE   = 0;
    localparam int SPI_BIT_ACCESS   = 0;
    localparam int SPI_NUM_SRC      = 4;
    // Source index inside the event vector
    localparam int SPI_SRC_BASE     = 0;
    localparam int SPI_SRC_SYSCTRL  = 1;
    localparam int SPI_SRC_AHB_EXP  = 2;
    localparam int SPI_SRC_BRIDGE   = 3;
    //=========================================================================
    // Reset values
    localparam logic [3:0]  SPI_RST_VEC    = 4'h0;
    localparam logic        SPI_RST_BIT    = 1'b0;
    localparam logic [31:0] SPI_RST_WORD   = 32'h0000_0000;
endpackage

// ### src/spi_flag.sv
`timescale 1ns/1ps
//=============================================================================
// Sticky pending flag; a set in the same cycle as a clear wins
module spi_flag
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic clkEn,
    // Control
    input  wire logic setEvt,
    input  wire logic clrEvt,
    // State
    output logic      flag
);
    import spi_pkg::*;

    always_ff @(posedge mclk)
    begin
        if (reset)
            flag <= SPI_RST_BIT;
        else if (clkEn)
        begin
            if (setEvt)
                flag <= 1'b1;
            else if (clrEvt)
                flag <= 1'b0;
        end
    end
endmodule // spi_flag

// ### test/spi_regs_properties.sv
`timescale 1ns/1ps
//=============================================================================
// Port checker for the register bank
module spi_regs_chk
    import spi_pkg::*;
(
    // Clock, reset and bus
    input wire logic        mclk, reset, clkEn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Events and outputs
    input wire logic        baseGuardEvt, sysctrlGuardEvt, ahbExpGuardEvt, coreBridgeErrEvt,
    input wire logic        baseGuardIrq, sysctrlGuardIrq, ahbExpGuardIrq, coreBridgeErrIrq, expansionNonSecure
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Irq lags the register by one more edge, hence the extra delay
    wire wr = pready && pwrite;
    wire rd = pready && !pwrite;
    property p_en_base; wr && paddr == SPI_OFS_PROT_ENABLE && !pwdata[0] |=> ##1 !baseGuardIrq; endproperty
    a_en_base: assert property (p_en_base) else $error("base irq on while off");
    property p_en_brg; wr && paddr == SPI_OFS_BRG_ENABLE && !pwdata[0] |=> ##1 !coreBridgeErrIrq; endproperty
    a_en_brg: assert property (p_en_brg) else $error("bridge irq on while off");
    property p_clr_ahb; wr && paddr == SPI_OFS_PROT_CLEAR && pwdata[20] && !ahbExpGuardEvt |=> ##1 !ahbExpGuardIrq;
    endproperty
    a_clr_ahb: assert property (p_clr_ahb) else $error("expansion irq not cleared");
    property p_clr_sys; wr && paddr == SPI_OFS_PROT_CLEAR && pwdata[1] && !sysctrlGuardEvt |=> ##1 !sysctrlGuardIrq;
    endproperty
    a_clr_sys: assert property (p_clr_sys) else $error("sysctrl irq not cleared");
    property p_clr_brg; wr && paddr == SPI_OFS_BRG_CLEAR && pwdata[0] && !coreBridgeErrEvt |=> ##1 !coreBridgeErrIrq;
    endproperty
    a_clr_brg: assert property (p_clr_brg) else $error("bridge irq not cleared");
    property p_access; wr && paddr == SPI_OFS_EXP_ACCESS |=> ##1 expansionNonSecure == $past(pwdata[0], 2); endproperty
    a_access: assert property (p_access) else $error("access output wrong");
    property p_clr_read; rd && paddr == SPI_OFS_PROT_CLEAR |-> prdata == 32'h0000_0000; endproperty
    a_clr_read: assert property (p_clr_read) else $error("clear register kept data");
    property p_stat_rsv; rd && paddr == SPI_OFS_PROT_STATUS |-> (prdata & 32'hffef_fffc) == 32'h0000_0000; endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits set");
    property p_brg_rsv; rd && paddr == SPI_OFS_BRG_STATUS |-> prdata[31:1] == 31'h0000_0000; endproperty
    a_brg_rsv: assert property (p_brg_rsv) else $error("bridge status reserved bits set");
    property p_en_ahb; wr && paddr == SPI_OFS_PROT_ENABLE && !pwdata[20] |=> ##1 !ahbExpGuardIrq; endproperty
    a_en_ahb: assert property (p_en_ahb) else $error("expansion irq on while off");
    c_irq: cover property (baseGuardIrq);
    c_err: cover property (pslverr);
    c_ns: cover property (expansionNonSecure);
endmodule // spi_regs_chk

bind spi_regs spi_regs_chk chk_u (.*);

// ### test/spi_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
//=============================================================================
// Bench for the register bank; bus tasks plus checked sequences
module spi_regs_tb_top;
    import spi_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic        clkEn = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q;
    logic [3:0]  ev = 4'h0;
    wire  [31:0] prdata;
    wire  [3:0]  irq;
    wire         pready, pslverr, nonSec;
    int          miscompares = 0, nTests = 0, cyc = 0;
    spi_regs dut_u (.mclk(mclk), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .baseGuardEvt(ev[0]), .sysctrlGuardEvt(ev[1]), .ahbExpGuardEvt(ev[2]), .coreBridgeErrEvt(ev[3]),
        .baseGuardIrq(irq[0]), .sysctrlGuardIrq(irq[1]), .ahbExpGuardIrq(irq[2]), .coreBridgeErrIrq(irq[3]),
        .expansionNonSecure(nonSec));
    initial forever #5 mclk = ~mclk;
    // Whole run needs well under a thousand cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            results();
        end
    end
    task results;
        $display("tests=%0d miscompares=%0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    //=========================================================================
    // Bus and event tasks
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Two extra edges let the irq outputs settle
    task wrR(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge mclk);
    endtask
    task chkRd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task evt(input logic [3:0] v);
        @(posedge mclk);
        ev <= v;
        @(posedge mclk);
        ev <= 4'h0;
        repeat (2) @(posedge mclk);
    endtask
    //=========================================================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        chkRd(SPI_OFS_PROT_ENABLE, 32'h0);
        chkRd(SPI_OFS_BRG_ENABLE, 32'h0);
        chkRd(SPI_OFS_EXP_ACCESS, 32'h0);
        chkRd(SPI_OFS_BRG_STATUS, 32'h0);
        evt(4'hf);
        chkRd(SPI_OFS_PROT_STATUS, 32'h0010_0003);
        chkRd(SPI_OFS_BRG_STATUS, 32'h1);
        `CHK(irq, 4'h0)
        wrR(SPI_OFS_BRG_STATUS, 32'h0);
        chkRd(SPI_OFS_BRG_STATUS, 32'h1);
        wrR(SPI_OFS_PROT_ENABLE, 32'hffff_ffff);
        chkRd(SPI_OFS_PROT_ENABLE, 32'h0010_0003);
        `CHK(irq, 4'h7)
        wrR(SPI_OFS_BRG_ENABLE, 32'h1);
        `CHK(irq, 4'hf)
        wrR(SPI_OFS_PROT_CLEAR, 32'h2);
        `CHK(irq, 4'hd)
        chkRd(SPI_OFS_PROT_CLEAR, 32'h0);
        wrR(SPI_OFS_PROT_CLEAR, 32'h0010_0001);
        `CHK(irq, 4'h8)
        chkRd(SPI_OFS_PROT_STATUS, 32'h0);
        wrR(SPI_OFS_BRG_CLEAR, 32'h1);
        chkRd(SPI_OFS_BRG_STATUS, 32'h0);
        wrR(SPI_OFS_PROT_ENABLE, 32'h2);
        evt(4'h3);
        `CHK(irq, 4'h2)
        wrR(SPI_OFS_PROT_ENABLE, 32'h0);
        wrR(SPI_OFS_BRG_ENABLE, 32'h0);
        `CHK(irq, 4'h0)
        wrR(SPI_OFS_EXP_ACCESS, 32'hffff_ffff);
        chkRd(SPI_OFS_EXP_ACCESS, 32'h1);
        `CHK(nonSec, 1'b1)
        // Mid-run reset must drop the access setting again
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        `CHK(nonSec, 1'b0)
        chkRd(SPI_OFS_EXP_ACCESS, 32'h0);
        // Frozen clock enable must ignore an event
        @(posedge mclk);
        clkEn <= 1'b0;
        evt(4'h8);
        @(posedge mclk);
        clkEn <= 1'b1;
        chkRd(SPI_OFS_BRG_STATUS, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        `CHK({err, q}, 33'h1_0000_0000)
        results();
    end
endmodule // spi_regs_tb_top
